// [vectored_irq_ctrl_defs.vh]
// Contract
// - Source 0 is the fast interrupt pin and drives the fast request line.
// - Source 1 is the combined system peripheral group request.
// - Every source has its own enable and vector; masked sources never interrupt.
// - Internal sources select edge or level detection by software.
// - External sources select rising, falling, high or low detection.
// - Eight-level priority resolver picks the pending source and drives normal request.
// - Strictly higher priority source re-asserts normal request during service.
// - Every source has a separate software-written vector register.
// - Current vector read returns the vector of the winning pending source.
// - In protect mode reads cause no automatic state change.
// - Software can redirect any source onto the fast request line.
// - General mask holds request lines off while pending is still recorded.
// - Sources 2-15 peripherals, 16-28 reserved, 29 and 30 external pins.
`ifndef VECTORED_IRQ_CTRL_DEFS_VH
`define VECTORED_IRQ_CTRL_DEFS_VH
`define OFS_MODE 10'h000
`define OFS_VECT 10'h080
`define OFS_CURVEC 10'h100
`define OFS_FASTVEC 10'h104
`define OFS_CURSRC 10'h108
`define OFS_PEND 10'h10c
`define OFS_ENABLED 10'h110
`define OFS_ENSET 10'h114
`define OFS_ENCLR 10'h118
`define OFS_PENDCLR 10'h11c
`define OFS_PENDSET 10'h120
`define OFS_EOI 10'h124
`define OFS_SPURVEC 10'h128
`define OFS_DBGCTL 10'h12c
`define OFS_FASTSEL 10'h130
`define OFS_EVTSTAT 10'h134
`define OFS_EVTMASK 10'h138
`define MODE_PRI_LSB 0
`define MODE_TYP_LSB 5
`define TYP_EDGE_BIT 0
`define TYP_POS_BIT 1
`define DBG_PROT_BIT 0
`define DBG_GMASK_BIT 1
`define EVT_SPUR_BIT 0
`define EVT_EOIERR_BIT 1
`define SRC_FAST 0
`define SRC_SYS 1
`define SRC_EXT_A 29
`define SRC_EXT_B 30
`define SRC_IMPL_MASK 32'h6000ffff
`define RST_PRI 3'h0
`define RST_TYP 2'h0
`define RST_WORD 32'h00000000
`endif

// [vectored_irq_ctrl.v]
`timescale 1ns/1ps
`include "vectored_irq_ctrl_defs.vh"
module vectored_irq_ctrl (
  input wire core_clk,
  input wire arst_n,
  input wire fastIrqInput,
  input wire extIrqInputA,
  input wire extIrqInputB,
  input wire sysIrq,
  input wire [13:0] periphIrq,
  input wire [9:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  output reg normal_irq_line_n,
  output reg fast_irq_line_n,
  output reg ctrlIrq
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // The three pin sources are the only ones with a polarity choice.
  function isExt;
    input integer src;
    begin
      isExt = (src == `SRC_FAST) || (src == `SRC_EXT_A) ||
              (src == `SRC_EXT_B);
    end
  endfunction

  function hit;
    input [9:0] a;
    input [9:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Reserved numbers keep no configuration and always read back as zero,
  // so software cannot park state where no source exists.
  function isImpl;
    input [4:0] src;
    reg [31:0] impl;
    begin
      impl = `SRC_IMPL_MASK;
      isImpl = impl[src];
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [2:0] pinMeta_q;
  reg [2:0] pinSync_q;
  reg [2:0] priQ [0:31];
  reg [1:0] typQ [0:31];
  reg [31:0] vectQ [0:31];
  reg [31:0] enable_q;
  reg [31:0] pend_q;
  reg [31:0] lvlPrev_q;
  reg [31:0] fastSel_q;
  reg [31:0] spurVec_q;
  reg protect_q;
  reg gmask_q;
  reg [2:0] stkPri [0:7];
  reg [4:0] stkSrc [0:7];
  reg [3:0] depth_q;
  reg [1:0] evt_q;
  reg [1:0] evtMask_q;
  // One loop index per process, so no variable has two drivers.
  integer n;
  integer k;
  integer c;
  integer s;

  // ---------------------------------------------------------------
  // Source map and detection
  // ---------------------------------------------------------------
  wire [31:0] rawSrc;
  wire [31:0] actLvl;
  wire [31:0] isEdge;
  // Bit 31 and the reserved block are tied low.
  assign rawSrc = {1'b0, pinSync_q[2], pinSync_q[1], 13'h0000,
                   periphIrq, sysIrq, pinSync_q[0]};

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : detect
      if (isExt(g)) begin : ext
        // Polarity bit clear means low level or falling edge.
        assign actLvl[g] = rawSrc[g] ~^ typQ[g][`TYP_POS_BIT];
      end else begin : intl
        assign actLvl[g] = rawSrc[g];
      end
      assign isEdge[g] = typQ[g][`TYP_EDGE_BIT];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Priority resolution
  // ---------------------------------------------------------------
  wire [31:0] fastMap;
  wire [31:0] normCand;
  wire fastAct;
  wire [2:0] topPri;
  wire [4:0] curSrc;
  reg [4:0] bestSrc;
  reg [2:0] bestPri;
  reg found;
  wire irqValid;

  // Fast-routed sources bypass the service stack; they stay pending
  // until software clears them or the input falls away.
  assign fastMap = fastSel_q | 32'h00000001;
  assign normCand = pend_q & enable_q & ~fastMap;
  assign fastAct = |(pend_q & enable_q & fastMap);
  // Depth zero means nothing is in service, so any enabled level may win.
  assign topPri = (depth_q == 4'h0) ? 3'h0 :
                  stkPri[depth_q[2:0] - 3'h1];
  assign curSrc = (depth_q == 4'h0) ? 5'h00 :
                  stkSrc[depth_q[2:0] - 3'h1];

  always @* begin
    bestSrc = 5'h00;
    bestPri = 3'h0;
    found = 1'b0;
    // Ascending scan with a strict compare keeps the lowest number on ties.
    for (n = 0; n < 32; n = n + 1) begin
      if (normCand[n] && (!found || priQ[n] > bestPri)) begin
        bestSrc = n[4:0];
        bestPri = priQ[n];
        found = 1'b1;
      end
    end
  end

  // Only a strictly higher level may interrupt the one in service.
  assign irqValid = found &&
                    (depth_q == 4'h0 || bestPri > topPri);

  // ---------------------------------------------------------------
  // Bus side effects
  // ---------------------------------------------------------------
  wire inModes;
  wire inVects;
  wire [4:0] idx;
  wire implIdx;
  wire ackDo;
  wire ackRead;
  wire push;
  wire eoi;
  wire fastClr;
  wire [31:0] ackMask;
  wire [31:0] swClr;
  wire [31:0] swSet;
  wire [1:0] evtSet;
  wire [1:0] evtClr;

  assign inModes = (regAddr[9:7] == 3'h0);
  assign inVects = (regAddr[9:7] == 3'h1);
  assign idx = regAddr[6:2];
  assign implIdx = isImpl(idx);
  // With protect set the acknowledge moves from the read to a write.
  assign ackRead = regRd && hit(regAddr, `OFS_CURVEC);
  assign ackDo = protect_q ? (regWr && hit(regAddr, `OFS_CURVEC))
                           : ackRead;
  assign push = ackDo && irqValid;
  assign eoi = regWr && hit(regAddr, `OFS_EOI);
  assign fastClr = regRd && hit(regAddr, `OFS_FASTVEC) && !protect_q;
  assign ackMask = push ? (32'h00000001 << bestSrc) : 32'h00000000;
  // Software set and clear reach edge sources only.
  assign swClr = (regWr && hit(regAddr, `OFS_PENDCLR)) ? regWdata
                                                       : 32'h00000000;
  assign swSet = (regWr && hit(regAddr, `OFS_PENDSET)) ? regWdata
                                                       : 32'h00000000;
  assign evtSet[`EVT_SPUR_BIT] = ackDo && !irqValid;
  assign evtSet[`EVT_EOIERR_BIT] = eoi && (depth_q == 4'h0);
  assign evtClr = (regWr && hit(regAddr, `OFS_EVTSTAT)) ? regWdata[1:0]
                                                        : 2'h0;

  // ---------------------------------------------------------------
  // Pending and configuration registers
  // ---------------------------------------------------------------
  reg [31:0] pend_d;
  always @* begin
    pend_d = pend_q;
    for (k = 0; k < 32; k = k + 1) begin
      if (isEdge[k]) begin
        // A new edge in the clearing cycle survives the clear.
        pend_d[k] = (pend_q[k] & ~swClr[k] & ~ackMask[k] &
                     ~(fastClr && k == `SRC_FAST)) |
                    (actLvl[k] & ~lvlPrev_q[k]) | swSet[k];
      end else begin
        pend_d[k] = actLvl[k];
      end
    end
    // Reserved bits stay low so a stray software set makes no phantom.
    pend_d = pend_d & `SRC_IMPL_MASK;
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_q <= 3'h0;
      pinSync_q <= 3'h0;
      pend_q <= `RST_WORD;
      lvlPrev_q <= `RST_WORD;
    end else begin
      // Only the second stage feeds the detectors; the first may be unsettled.
      pinMeta_q <= {extIrqInputB, extIrqInputA, fastIrqInput};
      pinSync_q <= pinMeta_q;
      pend_q <= pend_d;
      lvlPrev_q <= actLvl;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (c = 0; c < 32; c = c + 1) begin
        priQ[c] <= `RST_PRI;
        typQ[c] <= `RST_TYP;
        vectQ[c] <= `RST_WORD;
      end
      enable_q <= `RST_WORD;
      fastSel_q <= `RST_WORD;
      spurVec_q <= `RST_WORD;
      protect_q <= 1'b0;
      gmask_q <= 1'b0;
      evtMask_q <= 2'h0;
    end else if (regWr) begin
      if (inModes && implIdx) begin
        priQ[idx] <= regWdata[`MODE_PRI_LSB +: 3];
        typQ[idx] <= regWdata[`MODE_TYP_LSB +: 2];
      end
      if (inVects && implIdx) begin
        vectQ[idx] <= regWdata;
      end
      if (hit(regAddr, `OFS_ENSET)) begin
        enable_q <= (enable_q | regWdata) & `SRC_IMPL_MASK;
      end
      if (hit(regAddr, `OFS_ENCLR)) begin
        enable_q <= enable_q & ~regWdata;
      end
      if (hit(regAddr, `OFS_FASTSEL)) begin
        fastSel_q <= regWdata & `SRC_IMPL_MASK;
      end
      if (hit(regAddr, `OFS_SPURVEC)) begin
        spurVec_q <= regWdata;
      end
      if (hit(regAddr, `OFS_DBGCTL)) begin
        protect_q <= regWdata[`DBG_PROT_BIT];
        gmask_q <= regWdata[`DBG_GMASK_BIT];
      end
      if (hit(regAddr, `OFS_EVTMASK)) begin
        evtMask_q <= regWdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Service stack
  // ---------------------------------------------------------------
  // Depth never passes eight: each push needs a strictly higher level.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (s = 0; s < 8; s = s + 1) begin
        stkPri[s] <= 3'h0;
        stkSrc[s] <= 5'h00;
      end
      depth_q <= 4'h0;
    end else if (push && depth_q != 4'h8) begin
      stkPri[depth_q[2:0]] <= bestPri;
      stkSrc[depth_q[2:0]] <= bestSrc;
      depth_q <= depth_q + 4'h1;
    end else if (eoi && depth_q != 4'h0) begin
      // An end of service with nothing in service only raises an event.
      depth_q <= depth_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if ((inModes || inVects) && !implIdx) begin
      rd_d = 32'h00000000;
    end else if (inModes) begin
      rd_d = {25'h0000000, typQ[idx], 2'h0, priQ[idx]};
    end else if (inVects) begin
      rd_d = vectQ[idx];
    end else begin
      case (regAddr)
        `OFS_CURVEC: rd_d = irqValid ? vectQ[bestSrc] : spurVec_q;
        `OFS_FASTVEC: rd_d = vectQ[`SRC_FAST];
        `OFS_CURSRC: rd_d = {27'h0000000, curSrc};
        `OFS_PEND: rd_d = pend_q;
        `OFS_ENABLED: rd_d = enable_q;
        `OFS_SPURVEC: rd_d = spurVec_q;
        `OFS_DBGCTL: rd_d = {30'h00000000, gmask_q, protect_q};
        `OFS_FASTSEL: rd_d = fastSel_q;
        `OFS_EVTSTAT: rd_d = {30'h00000000, evt_q};
        `OFS_EVTMASK: rd_d = {30'h00000000, evtMask_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Both lines are registered, so they trail the resolver by one cycle:
  // a request stays low on the acknowledging edge and rises one later.
  wire normalReq;
  wire fastReq;
  wire [1:0] evtNext;
  assign normalReq = irqValid && !gmask_q;
  assign fastReq = fastAct && !gmask_q;
  // An event in the cycle of its write-one clear stays set.
  assign evtNext = (evt_q & ~evtClr) | evtSet;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h00000000;
      normal_irq_line_n <= 1'b1;
      fast_irq_line_n <= 1'b1;
      evt_q <= 2'h0;
      ctrlIrq <= 1'b0;
    end else begin
      regRdata <= regRd ? rd_d : 32'h00000000;
      normal_irq_line_n <= ~normalReq;
      fast_irq_line_n <= ~fastReq;
      evt_q <= evtNext;
      ctrlIrq <= |(evtNext & evtMask_q);
    end
  end

endmodule // vectored_irq_ctrl

// [irq_core_model.sv]
`timescale 1ns/1ps
// ------------
// Core side
// ------------
module irq_core_model (
  input wire core_clk,
  input wire arst_n,
  input wire normal_irq_line_n,
  input wire fast_irq_line_n,
  output reg irqTaken,
  output reg fiqTaken
);
  // The core samples its request lines once a cycle, so a glitch that
  // settles before the edge is never taken.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqTaken <= 1'h0;
      fiqTaken <= 1'h0;
    end else begin
      irqTaken <= !normal_irq_line_n;
      fiqTaken <= !fast_irq_line_n;
    end
  end
endmodule // irq_core_model

// [vectored_irq_ctrl_checker.sv]
`timescale 1ns/1ps
`include "vectored_irq_ctrl_defs.vh"
module vectored_irq_ctrl_checker (
  input wire core_clk,
  input wire arst_n,
  input wire fastIrqInput,
  input wire extIrqInputA,
  input wire extIrqInputB,
  input wire sysIrq,
  input wire [13:0] periphIrq,
  input wire [9:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdata,
  input wire normal_irq_line_n,
  input wire fast_irq_line_n,
  input wire ctrlIrq
);
  // ------------
  // Shadow state
  // ------------
  reg [31:0] enMask_q;
  reg [31:0] fastSel_q;
  reg gMask_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enMask_q <= 32'h0;
      fastSel_q <= 32'h0;
      gMask_q <= 1'h0;
    end else if (regWr) begin
      if (regAddr == 10'h114) enMask_q <= enMask_q | regWdata & 32'h6000ffff;
      if (regAddr == 10'h118) enMask_q <= enMask_q & ~regWdata;
      if (regAddr == 10'h130) fastSel_q <= regWdata;
      if (regAddr == 10'h12c) gMask_q <= regWdata[1];
    end
  end
  // Lines are registered, so each quiet condition must hold two edges.
  wire noEn = enMask_q == 32'h0;
  wire noFast = (enMask_q & (fastSel_q | 32'h1)) == 32'h0;
  wire noNorm = (enMask_q & ~fastSel_q & ~32'h1) == 32'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  read_idle_a: assert property (
    !$past(regRd) |-> regRdata == 32'h0) else $error("Stray read data.");
  vec_readback_a: assert property (
    regWr && regAddr[9:7] == 3'h1 && `SRC_IMPL_MASK >> regAddr[6:2] & 1
    ##1 regRd && regAddr == $past(regAddr)
    |=> regRdata == $past(regWdata, 2)) else $error("Vector lost.");
  reserved_src_a: assert property (
    $past(regRd) && $past(regAddr[9:8]) == 2'h0
    && $past(regAddr[6:2]) inside {[16:28]} |-> regRdata == 32'h0)
    else $error("Reserved source holds state.");
  en_readback_a: assert property (
    $past(regRd) && $past(regAddr) == 10'h110
    |-> regRdata == $past(enMask_q)) else $error("Enable set wrong.");
  masked_quiet_a: assert property (
    noEn && $past(noEn) |-> normal_irq_line_n && fast_irq_line_n)
    else $error("Request with all sources masked.");
  gmask_quiet_a: assert property (
    gMask_q && $past(gMask_q) |-> normal_irq_line_n && fast_irq_line_n)
    else $error("Request under general mask.");
  fast_route_a: assert property (
    noFast && $past(noFast) |-> fast_irq_line_n)
    else $error("Fast request with no fast source.");
  normal_route_a: assert property (
    noNorm && $past(noNorm) |-> normal_irq_line_n)
    else $error("Normal request with no normal source.");
  cover property (!normal_irq_line_n);
  cover property (!fast_irq_line_n);
  cover property (ctrlIrq);
endmodule // vectored_irq_ctrl_checker

// [vectored_irq_ctrl_bench.sv]
`timescale 1ns/1ps
module vectored_irq_ctrl_bench;
  // Source 0 resets to low-level detection, so its pin idles high.
  reg core_clk = 1'h0, arst_n = 1'h0, fastIrqInput = 1'h1, sysIrq = 1'h0;
  reg extIrqInputA = 1'h1, extIrqInputB = 1'h1, regWr = 1'h0, regRd = 1'h0;
  reg [13:0] periphIrq = 14'h0;
  reg [9:0] regAddr = 10'h0;
  reg [31:0] regWdata = 32'h0;
  wire [31:0] regRdata;
  wire normal_irq_line_n, fast_irq_line_n, ctrlIrq, irqTaken, fiqTaken;
  integer mismatches = 0, n_checks = 0, seed = 32'hca70e1e3, i, t;
  integer vec [0:31];
  integer stk [$];
  vectored_irq_ctrl dut_u (.*);
  irq_core_model core_u (.*);
  initial forever #5 core_clk = ~core_clk;
  // ------------
  // Bus and checks
  // ------------
  task bus(input w, input r, input [9:0] a, input [31:0] d);
    @(posedge core_clk);
    {regWr, regRd, regAddr, regWdata} <= {w, r, a, d};
  endtask
  task wr(input [9:0] a, input [31:0] d);
    bus(1, 0, a, d);
    bus(0, 0, a, 0);
  endtask
  task chk(input string n, input [31:0] e, input [31:0] s);
    n_checks = n_checks + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task rc(input string n, input [9:0] a, input [31:0] e);
    bus(0, 1, a, 0);
    bus(0, 0, a, 0);
    #1 chk(n, e, regRdata);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task waitLine(input f);
    #1;
    for (t = 0; t < 20 && (f ? fiqTaken : irqTaken) !== 1'h1; t = t + 1)
      @(posedge core_clk) #1;
    if (t == 20) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  endtask
  task ack(input integer s);
    rc("vector", 10'h100, vec[s]);
    stk.push_back(s);
  endtask
  task eoi;
    wr(10'h124, 0);
    void'(stk.pop_back());
    rc("cursrc", 10'h108, stk.size() ? stk[$] : 0);
  endtask
  task pulse2;
    @(posedge core_clk) periphIrq <= 14'h1;
    @(posedge core_clk) periphIrq <= 14'h0;
  endtask
  task ce(input e);
    @(posedge core_clk);
    #1 chk("ctrl", e, ctrlIrq);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'h1;
    rc("enabled", 10'h110, 0);
    rc("unmapped", 10'h200, 0);
    for (i = 0; i < 31; i = i + 1) begin
      vec[i] = $random(seed);
      bus(1, 0, 12'h80 + 4 * i, vec[i]);
      if (i > 15 && i < 29) vec[i] = 0;
      rc("vector", 12'h80 + 4 * i, vec[i]);
    end
    $display("test vectors done");
    wr(10'h008, 32'h22);
    wr(10'h00c, 32'h05);
    wr(10'h004, 32'h04);
    wr(10'h114, 32'he);
    pulse2;
    waitLine(0);
    ack(2);
    // The request line rises one edge after the acknowledging read.
    @(posedge core_clk) #1 chk("normal_irq_line_n", 1, normal_irq_line_n);
    @(posedge core_clk) periphIrq <= 14'h2;
    waitLine(0);
    ack(3);
    @(posedge core_clk) sysIrq <= 1'h1;
    repeat (4) @(posedge core_clk);
    #1 chk("normal_irq_line_n", 1, normal_irq_line_n);
    @(posedge core_clk) periphIrq <= 14'h0;
    wr(10'h12c, 32'h2);
    eoi;
    repeat (3) @(posedge core_clk);
    #1 chk("normal_irq_line_n", 1, normal_irq_line_n);
    rc("pending", 10'h10c, 32'h2);
    wr(10'h12c, 0);
    waitLine(0);
    ack(1);
    @(posedge core_clk) sysIrq <= 1'h0;
    eoi;
    eoi;
    $display("test nesting done");
    wr(10'h12c, 32'h1);
    pulse2;
    waitLine(0);
    rc("vector", 10'h100, vec[2]);
    rc("vector", 10'h100, vec[2]);
    chk("normal_irq_line_n", 0, normal_irq_line_n);
    wr(10'h100, 0);
    stk.push_back(2);
    eoi;
    wr(10'h12c, 0);
    $display("test protect done");
    wr(10'h114, 32'h60000000);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge core_clk) {extIrqInputB, extIrqInputA} <= {2{~i[1]}};
      wr(10'h074, i << 5);
      wr(10'h078, i << 5);
      wr(10'h11c, 32'h60000000);
      rc("ext idle", 10'h10c, 0);
      @(posedge core_clk) {extIrqInputB, extIrqInputA} <= {2{i[1]}};
      repeat (4) @(posedge core_clk);
      rc("ext active", 10'h10c, 32'h60000000);
      @(posedge core_clk) {extIrqInputB, extIrqInputA} <= {2{~i[1]}};
      repeat (4) @(posedge core_clk);
      rc("ext release", 10'h10c, i[0] ? 32'h60000000 : 0);
    end
    $display("test external done");
    wr(10'h118, 32'h60000000);
    @(posedge core_clk) fastIrqInput <= 1'h0;
    wr(10'h000, 32'h40);
    wr(10'h114, 32'h1);
    @(posedge core_clk) fastIrqInput <= 1'h1;
    waitLine(1);
    chk("normal_irq_line_n", 1, normal_irq_line_n);
    rc("fastvec", 10'h104, vec[0]);
    @(posedge core_clk) fastIrqInput <= 1'h0;
    wr(10'h130, 32'h8);
    repeat (3) @(posedge core_clk);
    #1 chk("fast_irq_line_n", 1, fast_irq_line_n);
    @(posedge core_clk) periphIrq <= 14'h2;
    waitLine(1);
    chk("normal_irq_line_n", 1, normal_irq_line_n);
    @(posedge core_clk) periphIrq <= 14'h0;
    $display("test fast done");
    wr(10'h128, 32'h5a5);
    wr(10'h138, 32'h1);
    rc("spurious", 10'h100, 32'h5a5);
    ce(1);
    wr(10'h138, 0);
    ce(0);
    wr(10'h138, 32'h1);
    ce(1);
    wr(10'h134, 32'h1);
    ce(0);
    rc("events", 10'h134, 0);
    wr(10'h124, 0);
    rc("events", 10'h134, 32'h2);
    $display("test events done");
    complete_run;
  end
endmodule // vectored_irq_ctrl_bench
bind vectored_irq_ctrl vectored_irq_ctrl_checker chk_u (.*);
